// ===== aihf_buf.sv
// Small FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; the drain side may stall at will.
`timescale 1ns/1ps
`default_nettype none
`include "aihf_params.svh"

module aihf_buf #(
	parameter int WIDTH = 19,
	parameter int DEPTH = `AIHF_BUF_DEPTH
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} aihf_buf_state_t;

	aihf_buf_state_t st_r;
	aihf_buf_state_t st_nxt;
	logic push;
	logic pop;

	always_comb begin
		st_nxt = st_r;
		in_ready_o = (st_r.count != DEPTH[AW:0]);
		out_valid_o = (st_r.count != '0);
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		if (push) begin
			st_nxt.slot[st_r.wr_ptr] = in_data_i;
			st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.count = st_r.count + 1'b1;
		end else if (pop && !push) begin
			st_nxt.count = st_r.count - 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_data_o = st_r.slot[st_r.rd_ptr];

endmodule // aihf_buf
`default_nettype wire

// ===== aihf_host.sv
// Host model taking data words, stalling as the bench asks.
// Assumes the block samples the handshake on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module aihf_host (
	input wire logic mclk_i,
	input wire logic [1:0] stall_i,
	output logic host_ready_o
);
	// ----
	// Ready pattern, changed at the falling edge
	// ----
	int seed = 26889;
	always @(negedge mclk_i) begin
		if (stall_i == 2'b00)
			host_ready_o <= 1'b1;
		else
			host_ready_o <= ($random(seed) & (stall_i == 2'b01 ? 1 : 7)) == 0;
	end
endmodule // aihf_host
`default_nettype wire

// ===== aihf_mem.sv
// Held-value memory: one word per channel, registered read data.
// Assumes a single synchronous write port and one read port per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "aihf_params.svh"

module aihf_mem
	import aihf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic rd_en_i,
	input wire logic [`AIHF_CHW-1:0] rd_addr_i,
	output logic [`AIHF_WW-1:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [`AIHF_CHW-1:0] wr_addr_i,
	input wire logic [`AIHF_WW-1:0] wr_data_i
);

	aihf_mem_state_t st_r;
	aihf_mem_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (rd_en_i) begin
			st_nxt.rd = st_r.words[rd_addr_i];
		end
		if (wr_en_i) begin
			st_nxt.words[wr_addr_i] = wr_data_i;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_o = st_r.rd;

endmodule // aihf_mem
`default_nettype wire

// ===== aihf_params.svh
// Constants for the analog input hold and format block.
// Assumes inclusion by every design file that needs a width, limit or code.
`ifndef AIHF_PARAMS_SVH
`define AIHF_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define AIHF_NCH 8
`define AIHF_CHW 3
`define AIHF_WW 16
`define AIHF_SELW 2
`define AIHF_BUF_DEPTH 2

// ----------------------------------------------------------------------
// Full-scale counts per resolution
// ----------------------------------------------------------------------
`define AIHF_MAX12 16'h0fff
`define AIHF_MAX14 16'h3fff
`define AIHF_MAX16 16'hffff

// ----------------------------------------------------------------------
// Right shift of the 16-bit converter code per resolution
// ----------------------------------------------------------------------
`define AIHF_SH12 4'h4
`define AIHF_SH14 4'h2
`define AIHF_SH16 4'h0

// ----------------------------------------------------------------------
// Packed BCD conversion of a 12-bit count
// ----------------------------------------------------------------------
`define AIHF_BCD_INW 12
`define AIHF_BCD_DIGITS 4
`define AIHF_BCD_DIGW 4
`define AIHF_BCD_ADJ_MIN 4'h5
`define AIHF_BCD_ADJ 4'h3

`endif

// ===== aihf_pkg.sv
// Types for the analog input hold and format block.
// Assumes aihf_params.svh is compiled with it.
`default_nettype none
`include "aihf_params.svh"

package aihf_pkg;

	// ------------------------------------------------------------------
	// Hold selection codes, one pair per channel
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		AIHF_HOLD_NONE  = 2'b00,
		AIHF_HOLD_MIN   = 2'b01,
		AIHF_HOLD_MAX   = 2'b10,
		AIHF_HOLD_RESET = 2'b11
	} aihf_hold_t;

	// ------------------------------------------------------------------
	// Resolution codes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		AIHF_RES_12 = 2'b00,
		AIHF_RES_14 = 2'b01,
		AIHF_RES_16 = 2'b10
	} aihf_res_t;

	// ------------------------------------------------------------------
	// State of the top module
	// ------------------------------------------------------------------
	typedef struct packed {
		logic s1_v;
		logic [`AIHF_CHW-1:0] s1_ch;
		logic [`AIHF_WW-1:0] s1_cnt;
		logic fwd_v;
		logic [`AIHF_WW-1:0] fwd_val;
		logic [`AIHF_NCH-1:0] armed;
		logic [`AIHF_NCH-1:0] seen;
		logic [`AIHF_NCH*`AIHF_SELW-1:0] prev_sel;
		logic span;
		logic bcd_err;
	} aihf_state_t;

	// ------------------------------------------------------------------
	// State of the held-value memory
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`AIHF_NCH-1:0][`AIHF_WW-1:0] words;
		logic [`AIHF_WW-1:0] rd;
	} aihf_mem_state_t;

endpackage
`default_nettype wire

// ===== aihf_top.sv
// Digital back end of an eight-channel voltage input: scaling to count,
// per-channel track and hold, and formatting into one 16-bit data word.
// Assumes converter codes arrive as 16-bit full-scale values, synchronous
// to mclk_i, and that configuration inputs are quasi-static levels.
`timescale 1ns/1ps
`default_nettype none
`include "aihf_params.svh"

module aihf_top
	import aihf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire logic [`AIHF_CHW-1:0] sample_chan_i,
	input wire logic [`AIHF_WW-1:0] sample_code_i,
	input wire logic [1:0] res_sel_i,
	input wire logic format_bcd_i,
	input wire logic input_span_select_i,
	input wire logic [`AIHF_NCH*`AIHF_SELW-1:0] hold_select_i,
	output logic front_span_o,
	output logic bcd_range_err_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [`AIHF_CHW-1:0] out_chan_o,
	output logic [`AIHF_WW-1:0] out_word_o
);

	localparam int BUF_W = `AIHF_CHW + `AIHF_WW;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Shift for the selected resolution; an unknown code acts as 16-bit
	function automatic logic [3:0] res_shift(input logic [1:0] res);
		logic [3:0] sh;
		sh = `AIHF_SH16;
		unique case (res)
			AIHF_RES_12: sh = `AIHF_SH12;
			AIHF_RES_14: sh = `AIHF_SH14;
			AIHF_RES_16: sh = `AIHF_SH16;
			default: sh = `AIHF_SH16;
		endcase
		return sh;
	endfunction

	// Largest count for the selected resolution
	function automatic logic [`AIHF_WW-1:0] res_max(input logic [1:0] res);
		logic [`AIHF_WW-1:0] m;
		m = `AIHF_MAX16;
		unique case (res)
			AIHF_RES_12: m = `AIHF_MAX12;
			AIHF_RES_14: m = `AIHF_MAX14;
			AIHF_RES_16: m = `AIHF_MAX16;
			default: m = `AIHF_MAX16;
		endcase
		return m;
	endfunction

	// Converter code to count; zero maps to 0, full scale to the maximum
	function automatic logic [`AIHF_WW-1:0] to_count(
		input logic [`AIHF_WW-1:0] code,
		input logic [1:0] res
	);
		logic [`AIHF_WW-1:0] c;
		c = (code >> res_shift(res)) & res_max(res);
		return c;
	endfunction

	// Selection pair of one channel from the selection word
	function automatic aihf_hold_t chan_sel(
		input logic [`AIHF_NCH*`AIHF_SELW-1:0] word,
		input logic [`AIHF_CHW-1:0] ch
	);
		logic hold_select_upper_bit;
		logic hold_select_lower_bit;
		hold_select_lower_bit = word[`AIHF_SELW*ch];
		hold_select_upper_bit = word[`AIHF_SELW*ch+1];
		return aihf_hold_t'({hold_select_upper_bit, hold_select_lower_bit});
	endfunction

	// Binary 12-bit count to four packed BCD digits
	function automatic logic [`AIHF_WW-1:0] to_bcd(input logic [`AIHF_BCD_INW-1:0] bin);
		logic [`AIHF_WW+`AIHF_BCD_INW-1:0] sh;
		sh = {{`AIHF_WW{1'b0}}, bin};
		for (int k = 0; k < `AIHF_BCD_INW; k++) begin
			for (int d = 0; d < `AIHF_BCD_DIGITS; d++) begin
				if (sh[`AIHF_BCD_INW+`AIHF_BCD_DIGW*d +: `AIHF_BCD_DIGW] >= `AIHF_BCD_ADJ_MIN) begin
					sh[`AIHF_BCD_INW+`AIHF_BCD_DIGW*d +: `AIHF_BCD_DIGW] =
						sh[`AIHF_BCD_INW+`AIHF_BCD_DIGW*d +: `AIHF_BCD_DIGW] + `AIHF_BCD_ADJ;
				end
			end
			sh = sh << 1;
		end
		return sh[`AIHF_WW+`AIHF_BCD_INW-1:`AIHF_BCD_INW];
	endfunction

	// ------------------------------------------------------------------
	// State and wiring
	// ------------------------------------------------------------------
	aihf_state_t st_r;
	aihf_state_t st_nxt;

	logic [`AIHF_WW-1:0] mem_rd_data;
	logic mem_rd_en;
	logic mem_wr_en;
	logic [`AIHF_WW-1:0] new_val;
	logic [`AIHF_WW-1:0] old_val;
	logic [`AIHF_WW-1:0] word_val;
	logic push;
	logic done;
	logic accept;
	logic buf_in_ready;
	logic [BUF_W-1:0] buf_out_data;
	aihf_hold_t cur_sel;

	// ------------------------------------------------------------------
	// Held values per channel
	// ------------------------------------------------------------------
	aihf_mem u_mem (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.rd_en_i(mem_rd_en),
		.rd_addr_i(sample_chan_i),
		.rd_data_o(mem_rd_data),
		.wr_en_i(mem_wr_en),
		.wr_addr_i(st_r.s1_ch),
		.wr_data_i(new_val)
	);

	// ------------------------------------------------------------------
	// Sample path, hold decision and arming
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cur_sel = chan_sel(hold_select_i, st_r.s1_ch);
		old_val = st_r.fwd_v ? st_r.fwd_val : mem_rd_data;
		new_val = st_r.s1_cnt;
		unique case (cur_sel)
			AIHF_HOLD_NONE: new_val = st_r.s1_cnt;
			AIHF_HOLD_RESET: new_val = st_r.s1_cnt;
			AIHF_HOLD_MIN: begin
				if (st_r.armed[st_r.s1_ch] || (st_r.s1_cnt < old_val)) begin
					new_val = st_r.s1_cnt;
				end else begin
					new_val = old_val;
				end
			end
			AIHF_HOLD_MAX: begin
				if (st_r.armed[st_r.s1_ch] || (st_r.s1_cnt > old_val)) begin
					new_val = st_r.s1_cnt;
				end else begin
					new_val = old_val;
				end
			end
		endcase

		// A word leaves only when the stored value changes or is first written
		push = st_r.s1_v && (!st_r.seen[st_r.s1_ch] || (new_val != old_val));
		done = st_r.s1_v && (!push || buf_in_ready);
		mem_wr_en = done;
		sample_ready_o = !st_r.s1_v || done;
		accept = sample_valid_i && sample_ready_o;
		mem_rd_en = accept;

		if (format_bcd_i && (res_sel_i == AIHF_RES_12)) begin
			word_val = to_bcd(new_val[`AIHF_BCD_INW-1:0]);
		end else begin
			word_val = new_val;
		end

		// Retire the sample in the second stage
		if (done) begin
			st_nxt.seen[st_r.s1_ch] = 1'b1;
			st_nxt.armed[st_r.s1_ch] = 1'b0;
			st_nxt.s1_v = 1'b0;
			st_nxt.fwd_v = 1'b0;
		end

		// Take a new sample; forward a same-channel write that lands now
		if (accept) begin
			st_nxt.s1_v = 1'b1;
			st_nxt.s1_ch = sample_chan_i;
			st_nxt.s1_cnt = to_count(sample_code_i, res_sel_i);
			st_nxt.fwd_v = done && (st_r.s1_ch == sample_chan_i);
			st_nxt.fwd_val = new_val;
		end

		// Arming wins over the clear above: a fresh capture follows any
		// change of selection and any time spent in no hold or reset
		for (int i = 0; i < `AIHF_NCH; i++) begin
			if ((chan_sel(hold_select_i, i[`AIHF_CHW-1:0]) !=
				chan_sel(st_r.prev_sel, i[`AIHF_CHW-1:0])) ||
				(chan_sel(hold_select_i, i[`AIHF_CHW-1:0]) == AIHF_HOLD_RESET) ||
				(chan_sel(hold_select_i, i[`AIHF_CHW-1:0]) == AIHF_HOLD_NONE)) begin
				st_nxt.armed[i] = 1'b1;
			end
		end
		st_nxt.prev_sel = hold_select_i;

		st_nxt.span = input_span_select_i;
		st_nxt.bcd_err = format_bcd_i && (res_sel_i != AIHF_RES_12);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
			st_r.armed <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Output buffer toward the host
	// ------------------------------------------------------------------
	aihf_buf #(
		.WIDTH(BUF_W),
		.DEPTH(`AIHF_BUF_DEPTH)
	) u_buf (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.in_valid_i(push),
		.in_ready_o(buf_in_ready),
		.in_data_i({st_r.s1_ch, word_val}),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(buf_out_data)
	);

	assign out_chan_o = buf_out_data[BUF_W-1:`AIHF_WW];
	assign out_word_o = buf_out_data[`AIHF_WW-1:0];
	assign front_span_o = st_r.span;
	assign bcd_range_err_o = st_r.bcd_err;

endmodule // aihf_top
`default_nettype wire

// ===== aihf_top_assertions.sv
// Port checker of the hold and format block.
// Assumes it is bound into aihf_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "aihf_params.svh"
module aihf_top_assertions (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic sample_valid_i,
	input wire logic sample_ready_o,
	input wire logic [1:0] res_sel_i,
	input wire logic format_bcd_i,
	input wire logic input_span_select_i,
	input wire logic front_span_o,
	input wire logic bcd_range_err_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i,
	input wire logic [`AIHF_CHW-1:0] out_chan_o,
	input wire logic [`AIHF_WW-1:0] out_word_o
);
	// ----
	// Checks
	// ----
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	sequence s_take;
		sample_valid_i && sample_ready_o;
	endsequence
	sequence s_stall;
		out_valid_o && !out_ready_i;
	endsequence
	a_span_copy: assert property (
		!$past(reset_i) |-> front_span_o == $past(input_span_select_i))
		else $error("span copy wrong");
	a_bcd_flag: assert property (
		!$past(reset_i) |-> bcd_range_err_o == $past(format_bcd_i && res_sel_i != 2'b00))
		else $error("bcd range flag wrong");
	a_stall_hold: assert property (
		s_stall |=> out_valid_o && $stable(out_word_o) && $stable(out_chan_o))
		else $error("word changed while stalled");
	a_pop_only: assert property (
		$fell(out_valid_o) |-> $past(out_ready_i))
		else $error("word dropped without take");
	a_word_latency: assert property (
		$rose(out_valid_o) |-> $past(sample_valid_i && sample_ready_o, 2))
		else $error("word without sample two cycles before");
	a_range_twelve: assert property (
		out_valid_o && res_sel_i == 2'b00 && !format_bcd_i |-> out_word_o[15:12] == 4'h0)
		else $error("12-bit word out of range");
	a_range_fourteen: assert property (
		out_valid_o && res_sel_i == 2'b01 |-> out_word_o[15:14] == 2'h0)
		else $error("14-bit word out of range");
	a_bcd_digit: assert property (
		out_valid_o && res_sel_i == 2'b00 && format_bcd_i |-> out_word_o[3:0] <= 4'h9
		&& out_word_o[7:4] <= 4'h9 && out_word_o[11:8] <= 4'h9 && out_word_o[15:12] <= 4'h4)
		else $error("bcd digit out of range");
	c_take: cover property (s_take ##2 out_valid_o);
endmodule // aihf_top_assertions
bind aihf_top aihf_top_assertions i_chk (.mclk_i, .reset_i, .sample_valid_i,
	.sample_ready_o, .res_sel_i, .format_bcd_i, .input_span_select_i, .front_span_o,
	.bcd_range_err_o, .out_valid_o, .out_ready_i, .out_chan_o, .out_word_o);
`default_nettype wire

// ===== aihf_top_tb.sv
// Self-checking bench of the hold and format block.
// Assumes aihf_host drives the output handshake.
`timescale 1ns/1ps
`default_nettype none
`include "aihf_params.svh"
module aihf_top_tb;
	// ----
	// Stimulus, model and checks
	// ----
	logic mclk_i = 0, reset_i = 1, sample_valid_i = 0, format_bcd_i = 0;
	logic input_span_select_i = 0;
	logic [2:0] sample_chan_i = 0;
	logic [15:0] sample_code_i = 0, hold_select_i = 0;
	logic [1:0] res_sel_i = 0, stall = 0;
	wire sample_ready_o, front_span_o, bcd_range_err_o, out_valid_o, out_ready_i;
	wire [2:0] out_chan_o;
	wire [15:0] out_word_o;
	int n_fail = 0, check_count = 0, seed = 26889;
	logic [15:0] stv [8];
	bit armd [8];
	bit seen [8];
	logic [18:0] q [$];
	always #4 mclk_i = ~mclk_i;
	aihf_top i_dut (.mclk_i, .reset_i, .sample_valid_i, .sample_ready_o, .sample_chan_i,
		.sample_code_i, .res_sel_i, .format_bcd_i, .input_span_select_i, .hold_select_i,
		.front_span_o, .bcd_range_err_o, .out_valid_o, .out_ready_i, .out_chan_o,
		.out_word_o);
	aihf_host i_host (.mclk_i, .stall_i(stall), .host_ready_o(out_ready_i));
	task automatic chk(string nm, logic [18:0] got, logic [18:0] exp_v);
		check_count++;
		if (got !== exp_v) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp_v, got);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic logic [15:0] fmt(logic [15:0] v);
		if (res_sel_i == 2'b00 && format_bcd_i)
			return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
		return v;
	endfunction
	task automatic model(logic [2:0] ch, logic [15:0] code);
		logic [1:0] s;
		logic [15:0] v;
		s = hold_select_i[2*ch +: 2];
		v = res_sel_i == 2'b00 ? code >> 4 : res_sel_i == 2'b01 ? code >> 2 : code;
		if (s == 2'b01 && !armd[ch] && stv[ch] < v) v = stv[ch];
		if (s == 2'b10 && !armd[ch] && stv[ch] > v) v = stv[ch];
		armd[ch] = s == 2'b00 || s == 2'b11;
		if (!seen[ch] || v != stv[ch]) q.push_back({ch, fmt(v)});
		stv[ch] = v;
		seen[ch] = 1;
	endtask
	task automatic send(logic [2:0] ch, logic [15:0] code);
		bit ok;
		int k;
		@(negedge mclk_i);
		sample_valid_i = 1;
		sample_chan_i = ch;
		sample_code_i = code;
		for (k = 0; k < 200; k++) begin
			#3 ok = sample_ready_o;
			@(posedge mclk_i);
			if (ok === 1'b1) break;
			@(negedge mclk_i);
		end
		chk("sample taken", 19'(ok), 19'h1);
		model(ch, code);
	endtask
	task automatic drain();
		int k;
		@(negedge mclk_i);
		sample_valid_i = 0;
		stall = 0;
		for (k = 0; k < 100 && q.size() > 0; k++) @(negedge mclk_i);
		repeat (4) @(negedge mclk_i);
		chk("words left", 19'(q.size()), 19'h0);
		chk("valid idle", 19'(out_valid_o), 19'h0);
	endtask
	always @(posedge mclk_i) begin
		if (!reset_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
			if (q.size() == 0)
				chk("extra word", {out_chan_o, out_word_o}, 19'h7ffff);
			else
				chk("word", {out_chan_o, out_word_o}, q.pop_front());
		end
	end
	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end
	initial begin
		int r, b, i;
		logic [15:0] sel;
		for (r = 0; r < 8; r++) begin
			@(negedge mclk_i);
			reset_i = 1;
			hold_select_i = 0;
			res_sel_i = 2'(r);
			format_bcd_i = r[2];
			input_span_select_i = r[0];
			for (i = 0; i < 8; i++) begin
				seen[i] = 0;
				armd[i] = 1;
			end
			repeat (20) @(negedge mclk_i);
			reset_i = 0;
			repeat (2) @(negedge mclk_i);
			chk("span", 19'(front_span_o), 19'(r[0]));
			chk("bcd flag", 19'(bcd_range_err_o), 19'(r[2] && r[1:0] != 0));
			send(0, 16'hffff);
			send(0, 16'h0000);
			send(0, 16'hffff);
			for (b = 0; b < 4; b++) begin
				sel = b == 0 ? 16'he4e4 : b == 1 ? 16'ha464 : 16'($random(seed));
				for (i = 0; i < 8; i++)
					if (sel[2*i +: 2] != hold_select_i[2*i +: 2]) armd[i] = 1;
				hold_select_i = sel;
				stall = 2'(b);
				for (i = 0; i < 40; i++) send(3'($random(seed)), 16'($random(seed)));
				drain();
			end
		end
		end_of_test();
	end
endmodule // aihf_top_tb
`default_nettype wire
